// *** verilog/pld_pkg.sv ***
// Constants and types shared by the port lamp driver
`default_nettype none
package pld_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_KHZ         = 25000;
  localparam int LAMP_ON_MS      = 1280;
  localparam int LAMP_OFF_MS     = 480;
  localparam int BLINK_SLOW_HZ   = 10;
  localparam int BLINK_FAST_HZ   = 20;
  localparam int LAMP_ON_CYC     = LAMP_ON_MS * CLK_KHZ;
  localparam int LAMP_OFF_CYC    = LAMP_OFF_MS * CLK_KHZ;
  localparam int BLINK_SLOW_HALF = (CLK_KHZ * 1000) / (2 * BLINK_SLOW_HZ);
  localparam int BLINK_FAST_HALF = (CLK_KHZ * 1000) / (2 * BLINK_FAST_HZ);
  localparam int PHASE_CNT_W     = 26;
  localparam int BLINK_CNT_W     = 22;

  // ----------------------------------------
  // Ports
  // ----------------------------------------
  localparam int NUM_PORTS   = 5;
  localparam int STRAP_PORTS = 3;

  // ----------------------------------------
  // Register map (word index, byte address is four times it)
  // ----------------------------------------
  localparam logic [7:0] DISP_CFG_IDX = 8'h12;
  localparam logic [7:0] HUB_CFG_IDX  = 8'h30;
  localparam logic [7:0] STATUS_IDX   = 8'h20;
  localparam int         DUP_ONLY_BIT = 0;
  localparam int         HUB_EN_BIT   = 0;
  localparam int         ST_PHASE_LSB = 0;
  localparam int         ST_STRAP_LSB = 4;
  localparam int         ST_COLOUR_BIT = 8;
  localparam logic       DISP_CFG_RST = 1'h0;
  localparam logic       HUB_CFG_RST  = 1'h0;
  localparam logic [2:0] STRAP_RST    = 3'h7;
  localparam logic       COLOUR_RST   = 1'h0;

  typedef enum logic [1:0] {PH_CAPTURE, PH_LAMP_ON, PH_LAMP_OFF, PH_NORMAL} pld_phase_type;
endpackage
`default_nettype wire

// *** verilog/pld_blink_gen.sv ***
// Free-running square wave divider for lamp blinking
`default_nettype none
module pld_blink_gen
  import pld_pkg::*;
#(
  parameter int HALF_CYC = BLINK_SLOW_HALF
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      phase_o
);
  // ----------------------------------------
  // Divider
  // ----------------------------------------
  logic [BLINK_CNT_W-1:0] cnt_r;
  logic [BLINK_CNT_W-1:0] cnt_nxt;
  logic                   phase_r;
  logic                   phase_nxt;

  always_comb begin
    cnt_nxt   = cnt_r + 1'b1;
    phase_nxt = phase_r;
    if (cnt_r == BLINK_CNT_W'(HALF_CYC - 1)) begin // R16
      cnt_nxt   = '0;
      phase_nxt = ~phase_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r   <= '0;
      phase_r <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      phase_r <= phase_nxt;
    end
  end

  assign phase_o = phase_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_BLINK_HALF: assert property (@(posedge clk_i) disable iff (rst_i) // R16
    (cnt_r == BLINK_CNT_W'(HALF_CYC - 1)) |=> (phase_r != $past(phase_r)))
    else $error("Blink phase did not toggle at half period");
  AST_BLINK_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // R16
    (cnt_r != BLINK_CNT_W'(HALF_CYC - 1)) |=> $stable(phase_r))
    else $error("Blink phase toggled early");
endmodule
`default_nettype wire

// *** verilog/pld_wb_regs.sv ***
// Classic Wishbone slave holding the lamp display configuration
`default_nettype none
module pld_wb_regs
  import pld_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  input  wire pld_phase_type phase_i,
  input  wire logic [2:0]    strap_i,
  input  wire logic          colour_i,
  output logic               duplex_only_select_o,
  output logic               hub_collision_lamp_enable_o
);
  function automatic logic [7:0] byte_addr(input logic [7:0] idx);
    return {idx[5:0], 2'h0};
  endfunction

  // ----------------------------------------
  // Decode and registers
  // ----------------------------------------
  logic        ack_r;
  logic        ack_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  logic        dup_r;
  logic        dup_nxt;
  logic        hub_r;
  logic        hub_nxt;
  logic        hit;

  assign hit = wb_cyc_i && wb_stb_i && !ack_r;

  always_comb begin
    ack_nxt = hit;
    dat_nxt = dat_r;
    dup_nxt = dup_r;
    hub_nxt = hub_r;
    if (hit) begin
      dat_nxt = 32'h0000_0000;
      if (wb_adr_i == byte_addr(DISP_CFG_IDX)) begin // R15
        dat_nxt[DUP_ONLY_BIT] = dup_r;
        if (wb_we_i && wb_sel_i[0]) begin
          dup_nxt = wb_dat_i[DUP_ONLY_BIT];
        end
      end else if (wb_adr_i == byte_addr(HUB_CFG_IDX)) begin // R15
        dat_nxt[HUB_EN_BIT] = hub_r;
        if (wb_we_i && wb_sel_i[0]) begin
          hub_nxt = wb_dat_i[HUB_EN_BIT];
        end
      end else if (wb_adr_i == byte_addr(STATUS_IDX)) begin
        dat_nxt[ST_PHASE_LSB +: 2] = phase_i;
        dat_nxt[ST_STRAP_LSB +: 3] = strap_i;
        dat_nxt[ST_COLOUR_BIT]     = colour_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
      dup_r <= DISP_CFG_RST;
      hub_r <= HUB_CFG_RST;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      dup_r <= dup_nxt;
      hub_r <= hub_nxt;
    end
  end

  assign wb_ack_o                    = ack_r;
  assign wb_dat_o                    = dat_r;
  assign duplex_only_select_o        = dup_r;
  assign hub_collision_lamp_enable_o = hub_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_ACK_SINGLE: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_r |=> !ack_r)
    else $error("Bus ack held for more than one cycle");
  AST_HUB_WRITE: assert property (@(posedge clk_i) disable iff (rst_i) // R15
    (hit && wb_we_i && wb_sel_i[0] && wb_adr_i == byte_addr(HUB_CFG_IDX))
    |=> (hub_r == $past(wb_dat_i[HUB_EN_BIT])))
    else $error("Hub collision enable not written");
endmodule
`default_nettype wire

// *** verilog/pld_top.sv ***
// Per-port link, speed and duplex lamp driver with power-on lamp test
//
// Implementation choices: the placing of the registers and the Wishbone register port.
`default_nettype none
// Behaviour
// (R01) Three lamps per port
// (R02) Link lamps fixed active low
// (R03) Lamp test: all lit 1.28 s
// (R04) Then all dark 0.48 s
// (R05) Link lamp: lit up, blinks on activity
// (R06) Speed lamp lit only at 100M
// (R07) Strap lamps 0-2 polarity from pin
// (R08) Strap lamps use strap in test
// (R09) Duplex lamp lit full, blinks collision
// (R10) Duplex-only mode: no collision blinking; with hub mode on, port 0-1 lamps still blink on collision
// (R11) Hub mode: 20 Hz collision by speed
// (R12) Ports 3-4 duplex lamps active low
// (R13) Colour mode latched unless init waiting
// (R14) Ports 0-2 polarity follows pull
// (R15) Options held in words 0x12, 0x30
// (R16) Counters divide clock for timing
module pld_top
  import pld_pkg::*;
#(
  parameter int NPORTS    = NUM_PORTS,
  parameter int ON_CYC    = LAMP_ON_CYC,
  parameter int OFF_CYC   = LAMP_OFF_CYC,
  parameter int SLOW_HALF = BLINK_SLOW_HALF,
  parameter int FAST_HALF = BLINK_FAST_HALF
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic [NPORTS-1:0] link_up_i,
  input  wire logic [NPORTS-1:0] speed_fast_i,
  input  wire logic [NPORTS-1:0] full_duplex_i,
  input  wire logic [NPORTS-1:0] activity_i,
  input  wire logic [NPORTS-1:0] collision_i,
  input  wire logic              serial_memory_data_in_pin_i,
  input  wire logic              init_wait_i,
  output logic      [NPORTS-1:0] link_activity_lamp_n_o,
  output logic      [NPORTS-1:0] speed_lamp_n_o,
  input  wire logic [2:0]        dupcol_strap_i,
  output logic      [2:0]        dupcol_strap_o,
  output logic                   dupcol_strap_oe_o,
  output logic      [NPORTS-4:0] dupcol_fixed_n_o,
  output logic                   colour_mode_o
);
  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  pld_phase_type phase_r;
  pld_phase_type phase_nxt;
  logic [2:0]    strap_r;
  logic [2:0]    strap_nxt;
  logic          colour_r;
  logic          colour_nxt;
  logic          duplex_only_select;
  logic          hub_collision_lamp_enable;
  logic          blink_slow;
  logic          blink_fast;

  pld_wb_regs u_regs (
    .clk_i                       (clk_i),
    .rst_i                       (rst_i),
    .wb_cyc_i                    (wb_cyc_i),
    .wb_stb_i                    (wb_stb_i),
    .wb_we_i                     (wb_we_i),
    .wb_adr_i                    (wb_adr_i),
    .wb_sel_i                    (wb_sel_i),
    .wb_dat_i                    (wb_dat_i),
    .wb_dat_o                    (wb_dat_o),
    .wb_ack_o                    (wb_ack_o),
    .phase_i                     (phase_r),
    .strap_i                     (strap_r),
    .colour_i                    (colour_r),
    .duplex_only_select_o        (duplex_only_select),
    .hub_collision_lamp_enable_o (hub_collision_lamp_enable)
  );

  // ----------------------------------------
  // Blink sources
  // ----------------------------------------
  pld_blink_gen #(.HALF_CYC(SLOW_HALF)) u_blink_slow (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .phase_o (blink_slow)
  );

  pld_blink_gen #(.HALF_CYC(FAST_HALF)) u_blink_fast (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .phase_o (blink_fast)
  );

  // ----------------------------------------
  // Lamp test sequencer and strap capture
  // ----------------------------------------
  logic [PHASE_CNT_W-1:0] cnt_r;
  logic [PHASE_CNT_W-1:0] cnt_nxt;

  always_comb begin
    phase_nxt  = phase_r;
    cnt_nxt    = cnt_r + 1'b1;
    strap_nxt  = strap_r;
    colour_nxt = colour_r;
    unique case (phase_r)
      PH_CAPTURE: begin
        strap_nxt = dupcol_strap_i; // R07 R14
        if (!init_wait_i) begin
          colour_nxt = serial_memory_data_in_pin_i; // R13
        end
        cnt_nxt   = '0;
        phase_nxt = PH_LAMP_ON;
      end
      PH_LAMP_ON: begin
        if (cnt_r == PHASE_CNT_W'(ON_CYC - 1)) begin // R03 R16
          cnt_nxt   = '0;
          phase_nxt = PH_LAMP_OFF;
        end
      end
      PH_LAMP_OFF: begin
        if (cnt_r == PHASE_CNT_W'(OFF_CYC - 1)) begin // R04 R16
          cnt_nxt   = '0;
          phase_nxt = PH_NORMAL;
        end
      end
      PH_NORMAL: begin
        cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_r  <= PH_CAPTURE;
      cnt_r    <= '0;
      strap_r  <= STRAP_RST;
      colour_r <= COLOUR_RST;
    end else begin
      phase_r  <= phase_nxt;
      cnt_r    <= cnt_nxt;
      strap_r  <= strap_nxt;
      colour_r <= colour_nxt;
    end
  end

  // ----------------------------------------
  // Normal display decisions (1 = lamp lit)
  // ----------------------------------------
  logic [NPORTS-1:0] act_lit;
  logic [NPORTS-1:0] spd_lit;
  logic [NPORTS-1:0] dup_lit;
  logic [NPORTS-1:0] full_link;
  logic [NPORTS-1:0] col_link;
  logic              slow_speed_collision;
  logic              fast_speed_collision;

  assign full_link = link_up_i & full_duplex_i;
  assign col_link  = link_up_i & collision_i;
  assign slow_speed_collision = |(col_link & ~full_duplex_i & ~speed_fast_i);
  assign fast_speed_collision = |(col_link & ~full_duplex_i & speed_fast_i);

  always_comb begin
    for (int p = 0; p < NPORTS; p++) begin
      act_lit[p] = link_up_i[p] && (!activity_i[p] || blink_slow); // R05
      spd_lit[p] = link_up_i[p] && speed_fast_i[p]; // R06
      if (duplex_only_select) begin
        dup_lit[p] = full_link[p]; // R10
      end else if (col_link[p]) begin
        dup_lit[p] = blink_slow; // R09 R12
      end else begin
        dup_lit[p] = full_link[p]; // R09 R12
      end
    end
    if (hub_collision_lamp_enable) begin
      dup_lit[0] = slow_speed_collision && blink_fast; // R11
      dup_lit[1] = fast_speed_collision && blink_fast; // R11
    end
  end

  // ----------------------------------------
  // Output stage
  // ----------------------------------------
  logic [NPORTS-1:0] act_lamp_r;
  logic [NPORTS-1:0] act_lamp_nxt;
  logic [NPORTS-1:0] spd_lamp_r;
  logic [NPORTS-1:0] spd_lamp_nxt;
  logic [NPORTS-1:0] dup_lamp_r;
  logic [NPORTS-1:0] dup_lamp_nxt;
  logic              oe_r;
  logic              oe_nxt;

  always_comb begin
    oe_nxt = (phase_nxt != PH_CAPTURE);
    unique case (phase_r)
      PH_LAMP_ON: begin
        act_lamp_nxt = '0; // R02 R03
        spd_lamp_nxt = '0; // R06
        dup_lamp_nxt = '0; // R12
        dup_lamp_nxt[2:0] = ~strap_r; // R08
      end
      PH_NORMAL: begin
        act_lamp_nxt = ~act_lit; // R02
        spd_lamp_nxt = ~spd_lit;
        dup_lamp_nxt = ~dup_lit; // R12
        dup_lamp_nxt[2:0] = dup_lit[2:0] ^ strap_r; // R07 R14
      end
      PH_CAPTURE, PH_LAMP_OFF: begin
        act_lamp_nxt = '1; // R04
        spd_lamp_nxt = '1;
        dup_lamp_nxt = '1;
        dup_lamp_nxt[2:0] = strap_nxt; // R08
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_lamp_r <= '1;
      spd_lamp_r <= '1;
      dup_lamp_r <= '1;
      oe_r       <= 1'b0;
    end else begin
      act_lamp_r <= act_lamp_nxt;
      spd_lamp_r <= spd_lamp_nxt;
      dup_lamp_r <= dup_lamp_nxt;
      oe_r       <= oe_nxt;
    end
  end

  // R01
  assign link_activity_lamp_n_o = act_lamp_r;
  assign speed_lamp_n_o         = spd_lamp_r;
  assign dupcol_strap_o         = dup_lamp_r[2:0];
  assign dupcol_strap_oe_o      = oe_r;
  assign dupcol_fixed_n_o       = dup_lamp_r[NPORTS-1:3];
  assign colour_mode_o          = colour_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_TEST_ON_LIT: assert property ((phase_r == PH_LAMP_ON) |=> // R03
    (act_lamp_r == '0 && spd_lamp_r == '0 && dup_lamp_r[2:0] == ~strap_r))
    else $error("Lamps not lit in lamp-on phase");
  AST_ON_LENGTH: assert property ((phase_r == PH_LAMP_ON && // R03
    cnt_r == PHASE_CNT_W'(ON_CYC - 1)) |=> (phase_r == PH_LAMP_OFF))
    else $error("Lamp-on phase length wrong");
  AST_OFF_LENGTH: assert property ((phase_r == PH_LAMP_OFF && // R04
    cnt_r != PHASE_CNT_W'(OFF_CYC - 1)) |=> (phase_r == PH_LAMP_OFF))
    else $error("Lamp-off phase ended early");
  AST_TEST_OFF_DARK: assert property ((phase_r == PH_LAMP_OFF) |=> // R08
    (act_lamp_r == '1 && dup_lamp_r[2:0] == strap_r && dupcol_fixed_n_o == '1))
    else $error("Lamps not dark in lamp-off phase");
  AST_LINK_DOWN: assert property ((phase_r == PH_NORMAL && !link_up_i[0]) |=> // R05
    (act_lamp_r[0] && spd_lamp_r[0]))
    else $error("Lamp lit with link down");
  AST_SPEED: assert property ((phase_r == PH_NORMAL) |=> // R06
    (spd_lamp_r == ~$past(spd_lit)))
    else $error("Speed lamp wrong");
  AST_DUP_ONLY: assert property ((phase_r == PH_NORMAL && duplex_only_select) |=> // R10
    (dupcol_fixed_n_o == ~$past(full_link[NPORTS-1:3])))
    else $error("Duplex-only lamp blinked or wrong");
  AST_HUB_DARK: assert property ((phase_r == PH_NORMAL && hub_collision_lamp_enable && // R11
    !slow_speed_collision) |=> (dupcol_strap_o[0] == strap_r[0]))
    else $error("Hub collision lamp lit without collision");
  AST_STRAP_HOLD: assert property ((phase_r != PH_CAPTURE) |=> $stable(strap_r)) // R07
    else $error("Strap changed after capture");
  AST_OE_CAPTURE: assert property ((phase_r == PH_CAPTURE) |-> !oe_r) // R07
    else $error("Strap pins driven during capture");
  AST_OE_NORMAL: assert property ((phase_r != PH_CAPTURE) |=> oe_r) // R07
    else $error("Strap pins released after capture");
  AST_ON_FIXED_LIT: assert property ((phase_r == PH_LAMP_ON) |=> // R12
    (dupcol_fixed_n_o == '0))
    else $error("Fixed duplex lamps not lit in lamp-on phase");
  AST_OFF_SPEED: assert property ((phase_r == PH_LAMP_OFF) |=> // R06
    (spd_lamp_r == '1))
    else $error("Speed lamps not dark in lamp-off phase");
  AST_ACT_STEADY: assert property ((phase_r == PH_NORMAL && link_up_i[0] && // R05
    !activity_i[0]) |=> !act_lamp_r[0])
    else $error("Link lamp not steady with link up");
  AST_DUP_FULL: assert property ((phase_r == PH_NORMAL && !duplex_only_select && // R09
    !hub_collision_lamp_enable && full_link[0] && !collision_i[0]) |=>
    (dupcol_strap_o[0] == ~strap_r[0]))
    else $error("Duplex lamp not lit for full duplex link");
  AST_HUB_FAST_DARK: assert property ((phase_r == PH_NORMAL && // R11
    hub_collision_lamp_enable && !fast_speed_collision) |=>
    (dupcol_strap_o[1] == strap_r[1]))
    else $error("Hub fast collision lamp lit without collision");

  COV_NORMAL: cover property ($rose(phase_r == PH_NORMAL));
  COV_COLLISION: cover property (phase_r == PH_NORMAL && col_link[NPORTS-1] &&
    !duplex_only_select);
  COV_DUP_ONLY: cover property (phase_r == PH_NORMAL && duplex_only_select && col_link[1]);
  COV_HUB: cover property (phase_r == PH_NORMAL && hub_collision_lamp_enable &&
    fast_speed_collision);
endmodule
`default_nettype wire

// *** sim/pld_led_board.sv ***
// Board model: pull resistors and indicator lamps on the strap pins
`default_nettype none
module pld_led_board #(
  parameter logic [2:0] PULL = 3'h2
) (
  input  wire logic [2:0] drv_i,
  input  wire logic       oe_i,
  output logic      [2:0] pin_o,
  output logic      [2:0] lit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Pin level and lamp state
  // ----------------------------------------
  assign pin_o = oe_i ? drv_i : PULL;
  assign lit_o = oe_i ? (drv_i ^ PULL) : 3'h0;
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the port lamp driver
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pld_pkg::*;
  localparam logic [2:0] PULL = 3'h2;
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic cyc = 0, stb = 0, we = 0, ack, pin_sm = 1, iwait = 0, oe, colour;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, rdat, q;
  logic [4:0] lnk = 0, fst = 0, full = 0, act = 0, col = 0, lnk_n, spd_n;
  logic [2:0] ds_o, pin, lit;
  logic [1:0] fx_n;
  int n_fail = 0, comparisons = 0, t;
  always #20 clk_i = ~clk_i;
  pld_top #(.ON_CYC(40), .OFF_CYC(20), .SLOW_HALF(4), .FAST_HALF(2)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .link_up_i(lnk), .speed_fast_i(fst), .full_duplex_i(full), .activity_i(act),
    .collision_i(col), .serial_memory_data_in_pin_i(pin_sm), .init_wait_i(iwait),
    .link_activity_lamp_n_o(lnk_n), .speed_lamp_n_o(spd_n), .dupcol_strap_i(pin),
    .dupcol_strap_o(ds_o), .dupcol_strap_oe_o(oe), .dupcol_fixed_n_o(fx_n),
    .colour_mode_o(colour));
  pld_led_board #(.PULL(PULL)) board (.drv_i(ds_o), .oe_i(oe), .pin_o(pin), .lit_o(lit));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = rdat;
    if (k >= 20) chk("ack", 1, 0);
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task automatic do_reset(input logic p, input logic iw);
    @(posedge clk_i);
    rst_i <= 1; pin_sm <= p; iwait <= iw;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: pick = lnk_n[0];
      1, 2, 3: pick = pin[w-1];
      default: pick = fx_n[1];
    endcase
  endfunction
  task automatic tog(input int w, input int e, input string nm);
    logic p;
    t = 0;
    repeat (2) @(posedge clk_i);
    p = pick(w);
    repeat (32) begin
      @(posedge clk_i);
      if (pick(w) !== p) t++;
      p = pick(w);
    end
    chk(nm, e, t);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    finish_test;
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    repeat (10) @(posedge clk_i);
    chk("lnk on", 0, lnk_n);
    chk("spd on", 0, spd_n);
    chk("fix on", 0, fx_n);
    chk("strap on", {~PULL}, ds_o);
    chk("lit on", 3'h7, lit);
    wb(0, 8'h80, 0);
    chk("status on", {23'h0, 1'b1, 1'b0, PULL, 4'h1}, q);
    chk("colour", 1, colour);
    repeat (38) @(posedge clk_i);
    chk("lnk off", 5'h1f, lnk_n);
    chk("spd off", 5'h1f, spd_n);
    chk("fix off", 2'h3, fx_n);
    chk("strap off", PULL, ds_o);
    wb(0, 8'h80, 0);
    chk("status off", {23'h0, 1'b1, 1'b0, PULL, 4'h2}, q);
    $display("test self_test done");
    repeat (20) @(posedge clk_i);
    wb(0, 8'h48, 0);
    chk("disp rst", 0, q);
    wb(0, 8'hc0, 0);
    chk("hub rst", 0, q);
    wb(1, 8'h10, 32'hffff_ffff);
    wb(0, 8'h10, 0);
    chk("unmapped", 0, q);
    wb(1, 8'h80, 32'h0000_0000);
    wb(0, 8'h80, 0);
    chk("status ro", {23'h0, 1'b1, 1'b0, PULL, 4'h3}, q);
    $display("test registers done");
    lnk <= 5'h1b; fst <= 5'h03; full <= 5'h09;
    repeat (3) @(posedge clk_i);
    chk("lnk norm", 5'h04, lnk_n);
    chk("spd norm", 5'h1c, spd_n);
    chk("lit norm", 3'h1, lit);
    chk("fix norm", 2'h2, fx_n);
    act <= 5'h05;
    tog(0, 8, "act blink");
    chk("act down", 1, lnk_n[2]);
    act <= 0; col <= 5'h12;
    tog(2, 8, "col blink");
    tog(4, 8, "fix blink");
    $display("test normal done");
    wb(1, 8'h48, 32'hffff_ffff);
    wb(0, 8'h48, 0);
    chk("disp rw", 1, q);
    tog(2, 0, "dup only");
    chk("dup lit", 3'h1, lit);
    wb(1, 8'h48, 0);
    wb(1, 8'hc0, 1);
    lnk <= 5'h1f;
    col <= 5'h14;
    tog(1, 16, "hub slow");
    chk("hub fast dark", 0, lit[1]);
    tog(3, 8, "hub port2");
    col <= 5'h02;
    tog(2, 16, "hub fast");
    chk("hub slow dark", 0, lit[0]);
    $display("test options done");
    do_reset(1, 1);
    repeat (5) @(posedge clk_i);
    chk("colour blocked", 0, colour);
    $display("test colour done");
    finish_test;
  end
endmodule
`default_nettype wire
